// [design/rcms_top.sv]
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none
module rcms_top (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic [4:0]  oneGigClk,
	input  wire logic [4:0]  oneGigLos,
	input  wire logic [2:0]  sixGigClk,
	input  wire logic [2:0]  sixGigLos,
	input  wire logic [7:0]  laneAutoSquelchEnable,
	input  wire logic [3:0]  tenGigClk,
	input  wire logic [3:0]  tenGigLos,
	input  wire logic [1:0]  pllClk,
	input  wire logic [1:0]  pllLock,
	output var  logic        recoveredClockOut,
	output var  logic [1:0]  pllDiffClockOut
);
	import rcms_pkg::*;

	logic          rstnMeta;
	logic          rstnSync;
	rcms_out_cfg_t outCfg;
	rcms_ten_cfg_t tenCfg;
	rcms_pll_cfg_t pllCfg;
	logic [35:0]   pinLevel;
	logic [13:0]   clkLvl;
	logic [13:0]   clkPrev;
	logic [13:0]   clkEdge;
	logic [11:0]   losLvl;
	logic [1:0]    lockLvl;
	logic [7:0]    laneSqLvl;
	rcms_sel_t     sel;
	logic [1:0]    tenIdx;
	logic [5:0]    stretchCnt;
	logic          preEvt;
	logic          run;
	logic          squelched;
	logic [31:0]   wmask;
	logic [31:0]   curWord;
	logic [31:0]   newWord;
	logic          wrTaken;

	// reset enters asynchronously, released through two flops
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstnMeta <= 1'b0;
			rstnSync <= 1'b0;
		end else begin
			rstnMeta <= 1'b1;
			rstnSync <= rstnMeta;
		end
	end

	rcms_sync #(
		.WIDTH(36)
	) u_pins (
		.ref_clk (ref_clk),
		.rstnSync(rstnSync),
		.async   ({laneAutoSquelchEnable, pllLock, tenGigLos, sixGigLos, oneGigLos,
			pllClk, tenGigClk, sixGigClk, oneGigClk}),
		.level   (pinLevel)
	);
	assign clkLvl    = pinLevel[13:0];
	assign losLvl    = pinLevel[25:14];
	assign lockLvl   = pinLevel[27:26];
	assign laneSqLvl = pinLevel[35:28];

	// edges per source so a source switch never fakes an edge
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			clkPrev <= 14'h0000;
		end else begin
			clkPrev <= clkLvl;
		end
	end
	assign clkEdge = clkLvl ^ clkPrev;
	assign tenIdx  = 2'(outCfg.srcCode - `RCMS_SRC_10G_BASE);

	// source decode; unmapped codes give no source and the output holds
	always_comb begin
		logic [4:0] c;
		c   = outCfg.srcCode;
		sel = '0;
		if (c >= `RCMS_SRC_1G_BASE && c < `RCMS_SRC_1G_BASE + 5'h05) begin
			sel.srcValid = 1'b1;
			sel.edgeSeen = clkEdge[3'(c - `RCMS_SRC_1G_BASE)];
			sel.loss     = losLvl[3'(c - `RCMS_SRC_1G_BASE)];
			sel.sqEna    = laneSqLvl[3'(c - `RCMS_SRC_1G_BASE)];
		end else if (c >= `RCMS_SRC_6G_BASE && c < `RCMS_SRC_6G_BASE + 5'h03) begin
			sel.srcValid = 1'b1;
			sel.edgeSeen = clkEdge[5 + 2'(c - `RCMS_SRC_6G_BASE)];
			sel.loss     = losLvl[5 + 2'(c - `RCMS_SRC_6G_BASE)];
			sel.sqEna    = laneSqLvl[5 + 2'(c - `RCMS_SRC_6G_BASE)];
		end else if (c >= `RCMS_SRC_10G_BASE && c < `RCMS_SRC_10G_BASE + 5'h04) begin
			sel.srcValid = 1'b1;
			sel.edgeSeen = clkEdge[8 + tenIdx];
			sel.loss     = losLvl[8 + tenIdx];
			sel.sqEna    = tenCfg.sqEna[tenIdx];
			sel.stretch  = tenCfg.preCode[tenIdx] == PRE_ADJ;
		end else if (c == `RCMS_SRC_PLL1) begin
			sel.srcValid = 1'b1;
			sel.edgeSeen = clkEdge[12];
			sel.loss     = !lockLvl[0];
			sel.sqEna    = pllCfg.sqEna[0];
		end else if (c == `RCMS_SRC_PLL2) begin
			sel.srcValid = 1'b1;
			sel.edgeSeen = clkEdge[13];
			sel.loss     = !lockLvl[1];
			sel.sqEna    = pllCfg.sqEna[1];
		end
	end

	// stretch swallows one edge in 33, so 32 half periods span 33: 161 to 156.25 MHz
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			stretchCnt <= 6'h00;
		end else if (!sel.stretch) begin
			stretchCnt <= 6'h00;
		end else if (sel.edgeSeen) begin
			stretchCnt <= (stretchCnt == `RCMS_STRETCH_EDGES - 6'h01) ? 6'h00
				: stretchCnt + 6'h01;
		end
	end
	assign preEvt = sel.edgeSeen
		&& !(sel.stretch && stretchCnt == `RCMS_STRETCH_EDGES - 6'h01);

	assign squelched = sel.sqEna && sel.loss;
	assign run       = outCfg.outEna && sel.srcValid && !squelched;

	rcms_divider u_div (
		.ref_clk (ref_clk),
		.rstnSync(rstnSync),
		.evt     (preEvt),
		.run     (run),
		.divisor (rcms_divisor(outCfg.divCode)),
		.clkOut  (recoveredClockOut)
	);

	// differential outputs copy the PLLs only when clock-out select asks for it
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			pllDiffClockOut <= 2'h0;
		end else begin
			pllDiffClockOut <= pllCfg.clkOutSel ? clkLvl[13:12] : 2'h0;
		end
	end

	// avalon slave: one wait cycle, then the access completes
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wrTaken = avs_write && !avs_waitrequest;

	always_comb begin
		case (avs_address)
			`RCMS_OFF_OUT_CFG: curWord = {19'h0, outCfg.srcCode, 1'b0, outCfg.divCode, 3'h0,
				outCfg.outEna};
			`RCMS_OFF_TEN_CFG: curWord = {20'h0, tenCfg.sqEna, tenCfg.preCode};
			`RCMS_OFF_PLL_CFG: curWord = {27'h0, pllCfg.clkOutSel, 2'h0, pllCfg.sqEna};
			`RCMS_OFF_STATUS:  curWord = {24'h0, losLvl[11:8], recoveredClockOut,
				sel.srcValid, run, squelched};
			default:           curWord = 32'h0;
		endcase
	end
	assign newWord = (curWord & ~wmask) | (avs_writedata & wmask);

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= curWord;
		end
	end

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			outCfg <= `RCMS_OUT_CFG_RST;
		end else if (wrTaken && avs_address == `RCMS_OFF_OUT_CFG) begin
			outCfg.outEna  <= newWord[`RCMS_ENA_POS];
			outCfg.divCode <= newWord[`RCMS_DIV_POS +: 3];
			outCfg.srcCode <= newWord[`RCMS_SRC_POS +: 5];
		end
	end

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			tenCfg <= rcms_ten_cfg_t'(`RCMS_TEN_CFG_RST);
		end else if (wrTaken && avs_address == `RCMS_OFF_TEN_CFG) begin
			tenCfg <= rcms_ten_cfg_t'({newWord[`RCMS_TSQ_POS +: 4], newWord[`RCMS_PRE_POS +: 8]});
		end
	end

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			pllCfg <= `RCMS_PLL_CFG_RST;
		end else if (wrTaken && avs_address == `RCMS_OFF_PLL_CFG) begin
			pllCfg.sqEna     <= newWord[`RCMS_PSQ_POS +: 2];
			pllCfg.clkOutSel <= newWord[`RCMS_PSEL_POS];
		end
	end

	property p_stretch_swallow;
		@(posedge ref_clk) disable iff (!rstnSync)
		sel.stretch && sel.edgeSeen && stretchCnt == 6'h20 |-> !preEvt;
	endproperty
	a_stretch_swallow: assert property (p_stretch_swallow) else $error("stretch edge passed");

	property p_stretch_pass;
		@(posedge ref_clk) disable iff (!rstnSync)
		sel.stretch && sel.edgeSeen && stretchCnt < 6'h20 |-> preEvt ##1
			(stretchCnt == $past(stretchCnt) + 6'h01);
	endproperty
	a_stretch_pass: assert property (p_stretch_pass) else $error("stretch dropped edge");

	property p_line_rate;
		@(posedge ref_clk) disable iff (!rstnSync)
		!sel.stretch |-> (preEvt == sel.edgeSeen) ##1 (stretchCnt == 6'h00);
	endproperty
	a_line_rate: assert property (p_line_rate) else $error("line rate edges altered");

	property p_pll_route;
		@(posedge ref_clk) disable iff (!rstnSync)
		outCfg.srcCode == 5'h15 |-> sel.edgeSeen == (clkLvl[13] != $past(clkLvl[13]));
	endproperty
	a_pll_route: assert property (p_pll_route) else $error("second PLL not routed");

	property p_pll_out;
		@(posedge ref_clk) disable iff (!rstnSync)
		pllCfg.clkOutSel ##1 pllCfg.clkOutSel |-> pllDiffClockOut == $past(clkLvl[13:12]);
	endproperty
	a_pll_out: assert property (p_pll_out) else $error("PLL clock out mismatch");

	property p_los_squelch;
		@(posedge ref_clk) disable iff (!rstnSync)
		sel.srcValid && sel.sqEna && sel.loss |=> $stable(recoveredClockOut);
	endproperty
	a_los_squelch: assert property (p_los_squelch) else $error("clock ran under squelch");

	property p_pll1_lock;
		@(posedge ref_clk) disable iff (!rstnSync)
		outCfg.srcCode == 5'h0c && pllCfg.sqEna[0] && !lockLvl[0] |-> !run;
	endproperty
	a_pll1_lock: assert property (p_pll1_lock) else $error("first PLL not squelched");

	property p_pll2_lock;
		@(posedge ref_clk) disable iff (!rstnSync)
		outCfg.srcCode == 5'h15 && pllCfg.sqEna[1] && !lockLvl[1] |-> !run;
	endproperty
	a_pll2_lock: assert property (p_pll2_lock) else $error("second PLL not squelched");

	property p_hold_level;
		@(posedge ref_clk) disable iff (!rstnSync)
		!run [*2] |-> $stable(recoveredClockOut) ##1 $stable(recoveredClockOut);
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("stopped clock moved");

	c_stretch:  cover property (@(posedge ref_clk) disable iff (!rstnSync)
		sel.stretch && sel.edgeSeen && stretchCnt == 6'h20);
	c_squelch:  cover property (@(posedge ref_clk) disable iff (!rstnSync)
		outCfg.outEna && $rose(squelched));
	c_pll_out:  cover property (@(posedge ref_clk) disable iff (!rstnSync)
		$rose(pllDiffClockOut[1]));
	c_div25:    cover property (@(posedge ref_clk) disable iff (!rstnSync)
		outCfg.divCode == 3'h6 && $rose(recoveredClockOut));
endmodule // rcms_top
`default_nettype wire

// [design/rcms_map.svh]
`ifndef RCMS_MAP_SVH
`define RCMS_MAP_SVH
// register byte offsets
`define RCMS_OFF_OUT_CFG   4'h0
`define RCMS_OFF_TEN_CFG   4'h4
`define RCMS_OFF_PLL_CFG   4'h8
`define RCMS_OFF_STATUS    4'hc
// field positions
`define RCMS_ENA_POS       0
`define RCMS_DIV_POS       4
`define RCMS_SRC_POS       8
`define RCMS_PRE_POS       0
`define RCMS_TSQ_POS       8
`define RCMS_PSQ_POS       0
`define RCMS_PSEL_POS      4
// reset values
`define RCMS_OUT_CFG_RST   9'h000
`define RCMS_TEN_CFG_RST   12'h000
`define RCMS_PLL_CFG_RST   3'h0
// source codes
`define RCMS_SRC_1G_BASE   5'h04
`define RCMS_SRC_6G_BASE   5'h09
`define RCMS_SRC_PLL1      5'h0c
`define RCMS_SRC_10G_BASE  5'h0e
`define RCMS_SRC_PLL2      5'h15
// predivider: 16 line cycles plus one stretched half period, in edges
`define RCMS_STRETCH_EDGES 6'h21
`endif

// [design/rcms_pkg.sv]
`default_nettype none
package rcms_pkg;
`include "rcms_map.svh"
	typedef enum logic [1:0] {
		PRE_RAW  = 2'h0,
		PRE_LINE = 2'h1,
		PRE_ADJ  = 2'h2,
		PRE_RSV  = 2'h3
	} rcms_pre_t;
	typedef struct packed {
		logic [4:0] srcCode;
		logic [2:0] divCode;
		logic       outEna;
	} rcms_out_cfg_t;
	typedef struct packed {
		logic [3:0]            sqEna;
		rcms_pre_t [3:0]       preCode;
	} rcms_ten_cfg_t;
	typedef struct packed {
		logic       clkOutSel;
		logic [1:0] sqEna;
	} rcms_pll_cfg_t;
	typedef struct packed {
		logic       srcValid;
		logic       edgeSeen;
		logic       loss;
		logic       sqEna;
		logic       stretch;
	} rcms_sel_t;
	function automatic logic [4:0] rcms_divisor(input logic [2:0] code);
		case (code)
			3'h0: rcms_divisor = 5'h01;
			3'h1: rcms_divisor = 5'h04;
			3'h2: rcms_divisor = 5'h02;
			3'h3: rcms_divisor = 5'h08;
			3'h4: rcms_divisor = 5'h05;
			3'h5: rcms_divisor = 5'h10;
			3'h6: rcms_divisor = 5'h19;
			default: rcms_divisor = 5'h01;
		endcase
	endfunction
endpackage
`default_nettype wire

// [design/rcms_sync.sv]
`default_nettype none
module rcms_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rstnSync,
	input  wire logic [WIDTH-1:0] async,
	output var  logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] ff1;
	logic [WIDTH-1:0] ff2;
	logic [WIDTH-1:0] ff3;

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			ff1 <= '0;
			ff2 <= '0;
			ff3 <= '0;
		end else begin
			ff1 <= async;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			level <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (ff2[i] == ff3[i]) begin
					level[i] <= ff2[i];
				end
			end
		end
	end
endmodule // rcms_sync
`default_nettype wire

// [design/rcms_divider.sv]
`default_nettype none
module rcms_divider (
	input  wire logic       ref_clk,
	input  wire logic       rstnSync,
	input  wire logic       evt,
	input  wire logic       run,
	input  wire logic [4:0] divisor,
	output var  logic       clkOut
);
	import rcms_pkg::*;
	logic [4:0] cnt;
	logic [4:0] gap;
	logic       toggle;
	logic [4:0] divPrev;
	logic       divChg;

	// toggling every divisor events keeps odd ratios at even duty
	assign toggle = run && evt && (cnt >= divisor - 5'h01);

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			cnt <= 5'h00;
		end else if (toggle) begin
			cnt <= 5'h00;
		end else if (run && evt) begin
			cnt <= cnt + 5'h01;
		end
	end

	// stopping freezes the level where it is, never cuts a phase short
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			clkOut <= 1'b0;
		end else if (toggle) begin
			clkOut <= ~clkOut;
		end
	end

	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			gap <= 5'h00;
		end else if (toggle) begin
			gap <= 5'h00;
		end else if (run && evt && gap != 5'h1f) begin
			gap <= gap + 5'h01;
		end
	end

	// a ratio change mid phase ends the running count against the new divisor, so that phase is not checked
	always_ff @(posedge ref_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			divPrev <= 5'h01;
			divChg  <= 1'b0;
		end else begin
			divPrev <= divisor;
			if (toggle) begin
				divChg <= 1'b0;
			end else if (divisor != divPrev) begin
				divChg <= 1'b1;
			end
		end
	end

	property p_div_ratio;
		@(posedge ref_clk) disable iff (!rstnSync)
		toggle && $stable(divisor) && !divChg |-> gap + 5'h01 == divisor;
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("divider ratio wrong");
endmodule // rcms_divider
`default_nettype wire

// [design/rcms_top_end.sv]
`default_nettype none
`default_nettype wire

// [verif/rcms_rx_model.sv]
`default_nettype none
// receiving side of the recovered clock: counts output toggles and
// keeps the shortest phase seen, the first phase after clr is skipped
// because it may have begun before the window
module rcms_rx_model (
	input  wire logic ref_clk,
	input  wire logic clr,
	input  wire logic clkIn,
	output var  int   toggles,
	output var  int   minHalf
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last = 1'b0;
	int   run  = 0;
	always @(posedge ref_clk) begin
		last <= clkIn;
		if (clr) begin
			toggles <= 0;
			minHalf <= 100000;
			run     <= -100000;
		end else if (clkIn !== last) begin
			toggles <= toggles + 1;
			if (run >= 0 && run < minHalf) begin
				minHalf <= run + 1;
			end
			run <= 0;
		end else begin
			run <= run + 1;
		end
	end
endmodule // rcms_rx_model
`default_nettype wire

// [verif/rcms_tb_top.sv]
`default_nettype none
module rcms_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk         = 1'b0;
	logic        rstn            = 1'b0;
	logic [3:0]  avs_address     = 4'h0;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h0;
	logic [3:0]  avs_byteenable  = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        src             = 1'b0;
	logic [1:0]  ph              = 2'h0;
	logic [11:0] losAll          = 12'h000;
	logic [7:0]  laneAutoSquelchEnable = 8'h00;
	logic [1:0]  pllLock         = 2'h3;
	logic        recoveredClockOut;
	logic [1:0]  pllDiffClockOut;
	logic        clr             = 1'b0;
	int          toggles;
	int          minHalf;
	int          evCnt           = 0;
	int          cyc             = 0;
	int          err_total       = 0;
	int          checked         = 0;
	int          dv[7]           = '{1, 4, 2, 8, 5, 16, 25};
	// one slow source feeds every lane, 4 ref cycles per level
	wire logic [4:0] oneGigClk  = {5{src}};
	wire logic [2:0] sixGigClk  = {3{src}};
	wire logic [3:0] tenGigClk  = {4{src}};
	wire logic [1:0] pllClk     = {2{src}};
	wire logic [4:0] oneGigLos  = losAll[4:0];
	wire logic [2:0] sixGigLos  = losAll[7:5];
	wire logic [3:0] tenGigLos  = losAll[11:8];

	rcms_top i_rcms_top (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.oneGigClk, .oneGigLos, .sixGigClk, .sixGigLos, .laneAutoSquelchEnable,
		.tenGigClk, .tenGigLos, .pllClk, .pllLock, .recoveredClockOut,
		.pllDiffClockOut);
	rcms_rx_model i_rcms_rx_model (.ref_clk, .clr, .clkIn(recoveredClockOut),
		.toggles, .minHalf);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			src   <= ~src;
			evCnt <= evCnt + 1;
		end
	end
	// hang guard, well above the length of the sequence below
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end

	task automatic bad(input logic [31:0] got, input logic [31:0] exp);
		err_total++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) bad(got, exp);
	endtask
	// phase of the window against the source allows one toggle either way
	task automatic chkNear(input int got, input int exp);
		checked++;
		if (got < exp - 1 || got > exp + 1) bad(got, exp);
	endtask
	task automatic bus(input logic isWr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= isWr;
		avs_read      <= ~isWr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 50) bad(32'h0, 32'h1);
	endtask
	task automatic cfg(input logic [2:0] div, input logic [4:0] s);
		logic [31:0] q;
		// the block stands for an internal output, so fast rates are legal here
		bus(1'b1, 4'h0, {19'h0, s, 1'b0, div, 3'h0, 1'b1}, q);
	endtask
	task automatic measure(input int n, output int t, output int e);
		int e0;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		e0 = evCnt;
		repeat (n) @(posedge ref_clk);
		t = toggles;
		e = evCnt - e0;
	endtask
	// output must stop and keep its level for 200 cycles; the caller checks the restart
	task automatic stopCheck(output logic lv);
		int t;
		int e;
		repeat (12) @(posedge ref_clk);
		lv = recoveredClockOut;
		measure(200, t, e);
		chk(t, 0);
		chk({31'h0, recoveredClockOut}, {31'h0, lv});
	endtask
	task automatic results();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		logic [31:0] q;
		logic        lv;
		int          t;
		int          e;
		int          ln;
		int          sc[3];
		int          lb[3];
		sc = '{14, 4, 9};
		lb = '{8, 0, 5};
		void'($urandom(32'h6090));
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int a = 0; a < 12; a += 4) begin
			bus(1'b0, 4'(a), 32'h0, q);
			chk(q, 32'h0);
		end
		bus(1'b1, 4'h1, 32'hffffffff, q);
		bus(1'b0, 4'h1, 32'h0, q);
		chk(q, 32'h0);
		for (int c = 0; c < 7; c++) begin
			ln = $urandom % 4;
			bus(1'b1, 4'h4, 32'h1 << (2 * ln), q);
			cfg(3'(c), 5'(14 + ln));
			measure(800, t, e);
			chkNear(t, e / dv[c]);
			chk({31'h0, minHalf >= 4 * dv[c] - 1}, 32'h1);
		end
		bus(1'b1, 4'h4, 32'h2, q);
		cfg(3'h0, 5'd14);
		measure(1320, t, e);
		chkNear(t, e - e / 33);
		cfg(3'h4, 5'd14);
		measure(2640, t, e);
		chkNear(t, (e - e / 33) / 5);
		for (int s = 12; s < 22; s += 9) begin
			cfg(3'h0, 5'(s));
			measure(400, t, e);
			chkNear(t, e);
		end
		cfg(3'h0, 5'd13);
		measure(200, t, e);
		chk(t, 0);
		bus(1'b1, 4'h8, 32'h3, q);
		for (int p = 0; p < 2; p++) begin
			cfg(3'h2, p ? 5'd21 : 5'd12);
			repeat (20) @(posedge ref_clk);
			pllLock[p] <= 1'b0;
			stopCheck(lv);
			bus(1'b0, 4'hc, 32'h0, q);
			chk(q, {28'h0, lv, 3'h5});
			pllLock <= 2'h3;
			measure(400, t, e);
			chkNear(t, e / 2);
			chk({31'h0, minHalf >= 8}, 32'h1);
		end
		bus(1'b1, 4'h4, 32'h101, q);
		laneAutoSquelchEnable <= 8'hff;
		for (int k = 0; k < 3; k++) begin
			cfg(3'h2, 5'(sc[k]));
			repeat (20) @(posedge ref_clk);
			losAll[lb[k]] <= 1'b1;
			stopCheck(lv);
			losAll <= 12'h000;
			measure(400, t, e);
			chkNear(t, e / 2);
			chk({31'h0, minHalf >= 8}, 32'h1);
		end
		laneAutoSquelchEnable <= 8'h00;
		losAll[0] <= 1'b1;
		cfg(3'h0, 5'd4);
		measure(200, t, e);
		chkNear(t, e);
		bus(1'b1, 4'h8, 32'h10, q);
		repeat (8) @(posedge ref_clk);
		t = 0;
		lv = pllDiffClockOut[0];
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			if (pllDiffClockOut[1] !== pllDiffClockOut[0]) t += 100;
			if (pllDiffClockOut[0] !== lv) t++;
			lv = pllDiffClockOut[0];
		end
		chkNear(t, 10);
		bus(1'b1, 4'h8, 32'h0, q);
		repeat (8) @(posedge ref_clk);
		chk({30'h0, pllDiffClockOut}, 32'h0);
		results();
	end
endmodule // rcms_tb_top
`default_nettype wire
